// *** core/comm_fault_status_bank.sv ***
/*
  Communication fault status bank: host UART, chain port, upper-stack,
  fault tone and heartbeat flags, read over Avalon-MM.
  Assumes all inputs synchronous to CORE_CLK; event inputs are pulses.
*/
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "comm_fault_defines.svh"
module comm_fault_status_bank
    import comm_fault_pkg::*;
#(
    parameter int HB_MIN_CYCLES = `HB_MIN_CYC,
    parameter int HB_MAX_CYCLES = `HB_MAX_CYC,
    parameter int CNT_W         = 18
) (
    // Clock, reset, enable
    input  wire logic            CORE_CLK,
    input  wire logic            RST_N,
    input  wire logic            CORE_CE,
    // Avalon-MM slave
    input  wire logic [15:0]     AVS_ADDRESS,
    input  wire logic            AVS_READ,
    input  wire logic            AVS_WRITE,
    input  wire logic [31:0]     AVS_WRITEDATA,
    input  wire logic [3:0]      AVS_BYTEENABLE,
    output logic      [31:0]     AVS_READDATA,
    output logic                 AVS_WAITREQUEST,
    // Fault events
    input  wire host_fault_type  HOST_FAULT,
    input  wire chain_fault_type LOW_FAULT,
    input  wire chain_fault_type HIGH_FAULT,
    input  wire stack_rx_type    STACK_RX,
    input  wire link_event_type  LOW_LINK,
    input  wire link_event_type  HIGH_LINK,
    // Summary
    output logic                 FAULT_OVERVIEW
);
    bus_state_type    state;
    bus_state_type    next_state;
    logic [31:0]      next_readdata;
    logic [7:0]       ctrl;
    logic [7:0]       next_ctrl;
    logic [13:0]      index;
    logic             wr_done;
    logic [3:0]       clr;
    logic [4:0]       host_flags;
    logic [7:0]       chain_flags;
    logic [2:0]       hb_flags;
    logic             upper_stack_fault_seen;
    logic             next_upper;
    logic             next_overview;
    logic             dir_sel;
    logic             hb_evt;
    logic             tone_evt;
    logic [CNT_W-1:0] hb_count;
    logic [CNT_W-1:0] next_hb_count;
    logic             hb_armed;
    logic             next_hb_armed;
    logic             hb_timeout;
    logic             hb_early;
    logic [2:0]       hb_set;
    logic [7:0]       stack_reg;

    assign index   = AVS_ADDRESS[15:2];
    assign wr_done = AVS_WRITE && state == BUS_DONE && CORE_CE;
    // Frozen core must not complete a transfer
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !(state == BUS_DONE && CORE_CE);
    assign dir_sel = ctrl[`CTRL_DIR_SEL];

    // Bus handshake and register writes
    always_comb
    begin
        next_state    = state;
        next_readdata = AVS_READDATA;
        next_ctrl     = ctrl;
        clr           = 4'h0;
        case (state)
            BUS_IDLE:
            begin
                if (AVS_READ || AVS_WRITE)
                    next_state = BUS_DONE;
                next_readdata = 32'h0000_0000;
                if (AVS_READ)
                begin
                    case (index)
                        `REG_HOST_UART_IDX:    next_readdata = {27'h0, host_flags};
                        `REG_CHAIN_PORT_IDX:   next_readdata = {24'h0, chain_flags};
                        `REG_STACK_TONE_IDX:   next_readdata = {24'h0, stack_reg};
                        `REG_MONITOR_CTRL_IDX: next_readdata = {24'h0, ctrl};
                        default:               next_readdata = 32'h0000_0000;
                    endcase
                end
            end
            BUS_DONE:
            begin
                next_state = BUS_IDLE;
                if (wr_done && AVS_BYTEENABLE[0])
                begin
                    if (index == `REG_MONITOR_CTRL_IDX)
                        next_ctrl = {2'h0, AVS_WRITEDATA[5:0]};
                    if (index == `REG_FLAG_CLEAR_IDX)
                        clr = AVS_WRITEDATA[3:0];
                end
            end
            default:
                next_state = BUS_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            state        <= BUS_IDLE;
            AVS_READDATA <= 32'h0000_0000;
            ctrl         <= `CTRL_RESET;
        end
        else if (CORE_CE)
        begin
            state        <= next_state;
            AVS_READDATA <= next_readdata;
            ctrl         <= next_ctrl;
        end
    end

    // Host UART and chain port flags
    comm_fault_flag #(.W(5)) u_host_flags (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .ce    (CORE_CE),
        .set   (HOST_FAULT),
        .clr   ({5{clr[`CLR_HOST]}}),
        .q     (host_flags)
    );

    comm_fault_flag #(.W(8)) u_chain_flags (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .ce    (CORE_CE),
        .set   ({LOW_FAULT, HIGH_FAULT}),
        .clr   ({8{clr[`CLR_CHAIN]}}),
        .q     (chain_flags)
    );

    // Heartbeat and tone supervision on the selected port
    always_comb
    begin
        hb_evt   = dir_sel ? HIGH_LINK.heartbeat  : LOW_LINK.heartbeat;
        tone_evt = dir_sel ? HIGH_LINK.fault_tone : LOW_LINK.fault_tone;
        hb_timeout = !hb_evt && hb_count == CNT_W'(HB_MAX_CYCLES - 1);
        // No previous heartbeat means nothing can be too early
        hb_early = hb_armed && hb_count < CNT_W'(HB_MIN_CYCLES - 1);
        next_hb_armed = hb_armed || hb_evt;
        if (hb_evt || hb_timeout)
            next_hb_count = '0;
        else
            next_hb_count = hb_count + {{(CNT_W-1){1'b0}}, 1'b1};
        hb_set[`S3_HEARTBEAT_MISSING_FLAG] = hb_timeout;
        hb_set[`S3_HEARTBEAT_TOO_FAST_FLAG] = (hb_evt || tone_evt) && hb_early;
        hb_set[`S3_TONE]    = tone_evt;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            hb_count <= '0;
            hb_armed <= 1'b0;
        end
        else if (CORE_CE)
        begin
            hb_count <= next_hb_count;
            hb_armed <= next_hb_armed;
        end
    end

    comm_fault_flag #(.W(3)) u_hb_flags (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .ce    (CORE_CE),
        .set   (hb_set),
        .clr   ({clr[`CLR_TONE], clr[`CLR_HB], clr[`CLR_HB]}),
        .q     (hb_flags)
    );

    // Upper-stack flag follows each received transaction
    always_comb
    begin
        next_upper = upper_stack_fault_seen;
        if (STACK_RX.valid)
            next_upper = |STACK_RX.fault_status;
        stack_reg = {4'h0, upper_stack_fault_seen, hb_flags};
        next_overview = (!ctrl[`CTRL_MASK_HOST]  && |host_flags)
                     || (!ctrl[`CTRL_MASK_CHAIN] && |chain_flags)
                     || (!ctrl[`CTRL_MASK_HB]
                         && (hb_flags[`S3_HEARTBEAT_TOO_FAST_FLAG] || hb_flags[`S3_HEARTBEAT_MISSING_FLAG]))
                     || (!ctrl[`CTRL_MASK_TONE]  && hb_flags[`S3_TONE])
                     || (!ctrl[`CTRL_MASK_UPPER] && upper_stack_fault_seen);
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            upper_stack_fault_seen <= 1'b0;
            FAULT_OVERVIEW         <= 1'b0;
        end
        else if (CORE_CE)
        begin
            upper_stack_fault_seen <= next_upper;
            FAULT_OVERVIEW         <= next_overview;
        end
    end

    // Checks
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_hb_flag_set;
        CORE_CE && !ctrl[`CTRL_MASK_HB] && (hb_set[`S3_HEARTBEAT_MISSING_FLAG] || hb_set[`S3_HEARTBEAT_TOO_FAST_FLAG]);
    endsequence

    // Summary only follows while the core runs and the mask stays open
    sequence s_overview_armed;
        CORE_CE && !ctrl[`CTRL_MASK_HB];
    endsequence

    sequence s_read_req;
        CORE_CE && AVS_READ && state == BUS_IDLE;
    endsequence

    a_upper_set: assert property (CORE_CE && STACK_RX.valid && |STACK_RX.fault_status
        |=> upper_stack_fault_seen) else $error("upper-stack flag not set");
    a_upper_clear: assert property (CORE_CE && STACK_RX.valid && STACK_RX.fault_status == 8'h00
        |=> !upper_stack_fault_seen) else $error("upper-stack flag not cleared");
    a_upper_hold: assert property (CORE_CE && !STACK_RX.valid
        |=> upper_stack_fault_seen == $past(upper_stack_fault_seen)) else $error("upper-stack flag moved");
    a_hb_missing: assert property (CORE_CE && !hb_evt && hb_count == CNT_W'(HB_MAX_CYCLES - 1)
        |=> hb_flags[`S3_HEARTBEAT_MISSING_FLAG] && hb_count == '0) else $error("missing heartbeat not flagged");
    a_hb_too_fast: assert property (CORE_CE && hb_evt && hb_armed && hb_count < CNT_W'(HB_MIN_CYCLES - 1)
        |=> hb_flags[`S3_HEARTBEAT_TOO_FAST_FLAG]) else $error("fast heartbeat not flagged");
    a_tone_early_fast: assert property (CORE_CE && tone_evt && hb_early
        |=> hb_flags[`S3_HEARTBEAT_TOO_FAST_FLAG] && hb_flags[`S3_TONE]) else $error("early tone not flagged fast");
    a_port_select: assert property (CORE_CE && !hb_flags[`S3_TONE]
        && !(dir_sel ? HIGH_LINK.fault_tone : LOW_LINK.fault_tone)
        |=> !hb_flags[`S3_TONE]) else $error("tone taken from unselected port");
    a_tone_flag: assert property (CORE_CE && tone_evt |=> hb_flags[`S3_TONE])
        else $error("fault tone not flagged");
    a_overview_hb: assert property (s_hb_flag_set ##1 s_overview_armed |=> FAULT_OVERVIEW)
        else $error("summary bit missed heartbeat fault");
    a_host_sticky: assert property (CORE_CE && HOST_FAULT.host_tx_response_err
        |=> host_flags[4] ##1 (host_flags[4] || $past(clr[`CLR_HOST]) || !$past(CORE_CE)))
        else $error("host flag not sticky");
    a_read_answer: assert property (s_read_req ##1 (CORE_CE && AVS_READ) |-> !AVS_WAITREQUEST)
        else $error("read not answered in one cycle");
endmodule
`default_nettype wire

// *** inc/comm_fault_defines.svh ***
/*
  Offsets, field positions, reset values and timing counts of the
  communication fault status bank. Assumes a 125 MHz core clock.
*/
// Summary of operation
// - Set upper-stack flag when a received transaction carries fault status from above.
// - Clear upper-stack flag only when received fault status shows no fault.
// - Set heartbeat-missing flag when no heartbeat arrives within the expected interval.
// - Set heartbeat-too-fast flag when heartbeats arrive more often than allowed.
// - A fault tone soon after a heartbeat also sets heartbeat-too-fast.
// - Supervise low-side port when direction select is 0, high side when 1.
// - Set fault-tone flag when a tone arrives on the supervised port.
// - Summary bit rises when heartbeat mask is 0 and a heartbeat flag is set.
`ifndef COMM_FAULT_DEFINES_SVH
`define COMM_FAULT_DEFINES_SVH

// Register indices; byte address is four times the index
`define REG_HOST_UART_IDX    14'h0530
`define REG_CHAIN_PORT_IDX   14'h0531
`define REG_STACK_TONE_IDX   14'h0532
`define REG_MONITOR_CTRL_IDX 14'h0540
`define REG_FLAG_CLEAR_IDX   14'h0541

`define FLAG_RESET 8'h00
`define CTRL_RESET 8'h00

// Control register fields
`define CTRL_DIR_SEL    0
`define CTRL_MASK_HOST  1
`define CTRL_MASK_CHAIN 2
`define CTRL_MASK_HB    3
`define CTRL_MASK_TONE  4
`define CTRL_MASK_UPPER 5

// Clear register fields, write one to clear
`define CLR_HOST  0
`define CLR_CHAIN 1
`define CLR_HB    2
`define CLR_TONE  3

// Stack, tone and heartbeat register fields
`define S3_HEARTBEAT_TOO_FAST_FLAG 0
`define S3_HEARTBEAT_MISSING_FLAG 1
`define S3_TONE    2
`define S3_UPPER   3

// Heartbeat timing
`define CORE_CLK_NS 8
`define HB_MIN_NS   1000
`define HB_MAX_NS   2000000
`define HB_MIN_CYC  ((`HB_MIN_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define HB_MAX_CYC  (`HB_MAX_NS / `CORE_CLK_NS)

`endif

// *** inc/comm_fault_pkg.sv ***
/*
  Types of the communication fault status bank.
  Assumes the defines header for numeric values.
*/
package comm_fault_pkg;

    typedef struct packed {
        logic host_tx_response_err;
        logic host_rx_response_err;
        logic host_rx_command_err;
        logic link_clear_seen;
        logic unexpected_stop_seen;
    } host_fault_type;

    typedef struct packed {
        logic tx_response_err;
        logic rx_response_err;
        logic rx_command_err;
        logic bit_err;
    } chain_fault_type;

    typedef struct packed {
        logic heartbeat;
        logic fault_tone;
    } link_event_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] fault_status;
    } stack_rx_type;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } bus_state_type;

endpackage

// *** core/comm_fault_flag.sv ***
/*
  Group of sticky fault flags with per-bit clear.
  Assumes set and clear are one-cycle pulses in the core clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "comm_fault_defines.svh"
module comm_fault_flag #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // Events
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    // Flags
    output logic      [W-1:0] q
);
    logic [W-1:0] next_q;

    // Set wins over a clear in the same cycle
    always_comb
    begin
        next_q = (q & ~clr) | set;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            q <= '0;
        else if (ce)
            q <= next_q;
    end
endmodule
`default_nettype wire

// *** bench/link_peer.sv ***
/*
  Far-side peer: sends heartbeats and fault tones on one port.
  Assumes pulses are sampled on the rising edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none
module link_peer
    import comm_fault_pkg::*;
(
    // Clock and setup
    input  wire logic          clk,
    input  wire logic          high_side,
    input  wire logic [7:0]    period,
    // Link events
    output var link_event_type low_link,
    output var link_event_type high_link
);
    logic [7:0] cnt  = 8'h00;
    logic       hb   = 1'b0;
    logic       tone = 1'b0;
    // Period 0 keeps the heartbeat line silent
    always @(posedge clk)
    begin
        cnt <= (period == 8'h00 || cnt >= period - 8'h01) ? 8'h00 : cnt + 8'h01;
        hb  <= period != 8'h00 && cnt == period - 8'h01;
    end
    task send_tone();
        @(posedge clk);
        tone <= 1'b1;
        @(posedge clk);
        tone <= 1'b0;
    endtask
    // Idle port stays at 0, the idle level of a pulse line
    assign low_link  = high_side ? 2'b00 : {hb, tone};
    assign high_link = high_side ? {hb, tone} : 2'b00;
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
/*
  Self-checking bench of the fault status bank.
  Assumes a short heartbeat window: 5 to 40 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import comm_fault_pkg::*;
    typedef struct {
        logic [4:0]  host;
        logic [3:0]  low;
        logic [3:0]  high;
        logic [15:0] addr;
        logic [7:0]  exp;
    } row_type;
    localparam logic [15:0] HA = 16'h14C0;
    localparam logic [15:0] CA = 16'h14C4;
    localparam logic [15:0] SA = 16'h14C8;
    localparam logic [15:0] TA = 16'h1500;
    localparam logic [15:0] LA = 16'h1504;
    row_type rows [6] = '{
        '{5'h10, 4'h0, 4'h0, HA, 8'h10}, '{5'h01, 4'h0, 4'h0, HA, 8'h01},
        '{5'h1F, 4'h0, 4'h0, HA, 8'h1F}, '{5'h00, 4'h8, 4'h0, CA, 8'h80},
        '{5'h00, 4'h0, 4'h1, CA, 8'h01}, '{5'h00, 4'hF, 4'hF, CA, 8'hFF}};
    logic [15:0] regs [4] = '{HA, CA, SA, TA};
    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            ce = 1'b1;
    logic [15:0]     address = 16'h0000;
    logic            rd_req = 1'b0;
    logic            wr_req = 1'b0;
    logic [31:0]     wdata = 32'h00000000;
    logic [31:0]     rdata;
    logic            waitreq;
    logic            overview;
    host_fault_type  host = '0;
    chain_fault_type low = '0;
    chain_fault_type high = '0;
    stack_rx_type    srx = '0;
    link_event_type  low_link;
    link_event_type  high_link;
    logic            peer_high = 1'b0;
    logic [7:0]      period = 8'h14;
    logic [31:0]     rd;
    int              fails = 0;
    int              checked = 0;
    int              cycles = 0;
    always #4 clk = ~clk;
    comm_fault_status_bank #(.HB_MIN_CYCLES(5), .HB_MAX_CYCLES(40), .CNT_W(18)) u_dut (
        .CORE_CLK(clk), .RST_N(rst_n), .CORE_CE(ce), .AVS_ADDRESS(address),
        .AVS_READ(rd_req), .AVS_WRITE(wr_req), .AVS_WRITEDATA(wdata),
        .AVS_BYTEENABLE(4'h1), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
        .HOST_FAULT(host), .LOW_FAULT(low), .HIGH_FAULT(high), .STACK_RX(srx),
        .LOW_LINK(low_link), .HIGH_LINK(high_link), .FAULT_OVERVIEW(overview));
    link_peer u_peer (.clk(clk), .high_side(peer_high), .period(period),
        .low_link(low_link), .high_link(high_link));
    task conclude();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Ceiling well above the several hundred cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            conclude();
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // Request held until waitrequest is sampled low
    task bus_rd(input logic [15:0] a);
        @(posedge clk);
        address <= a;
        rd_req <= 1'b1;
        do @(posedge clk); while (waitreq !== 1'b0);
        rd = rdata;
        rd_req <= 1'b0;
    endtask
    task bus_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        address <= a;
        wdata <= {24'h000000, d};
        wr_req <= 1'b1;
        do @(posedge clk); while (waitreq !== 1'b0);
        wr_req <= 1'b0;
    endtask
    task pulse(input row_type r, input stack_rx_type s);
        @(posedge clk);
        host <= r.host;
        low <= r.low;
        high <= r.high;
        srx <= s;
        @(posedge clk);
        host <= '0;
        low <= '0;
        high <= '0;
        srx <= '0;
    endtask
    task stat(input logic [7:0] m, input logic [7:0] e);
        bus_rd(SA);
        chk("stack tone heartbeat", {24'h000000, e}, rd & {24'h000000, m});
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            bus_wr(LA, 8'h0F);
            pulse(rows[i], '0);
            bus_rd(rows[i].addr);
            chk("event flags", {24'h000000, rows[i].exp}, rd);
        end
        $display("test table done");
        // Reset in mid-run while flags are set
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        foreach (regs[i])
        begin
            bus_rd(regs[i]);
            chk("reset value", 32'h00000000, rd);
        end
        bus_wr(SA, 8'hFF);
        stat(8'hFF, 8'h00);
        bus_rd(16'h1600);
        chk("unmapped", 32'h00000000, rd);
        // Frozen core drops events
        ce <= 1'b0;
        pulse(rows[2], '0);
        ce <= 1'b1;
        bus_rd(HA);
        chk("frozen host flags", 32'h00000000, rd);
        $display("test reset done");
        pulse('{default: '0}, '{1'b1, 8'h04});
        bus_wr(LA, 8'h0F);
        stat(8'h08, 8'h08);
        pulse('{default: '0}, '{1'b1, 8'h00});
        stat(8'h08, 8'h00);
        $display("test upper stack done");
        repeat (30) @(posedge clk);
        bus_wr(LA, 8'h04);
        bus_wr(TA, 8'h36);
        repeat (100) @(posedge clk);
        stat(8'h03, 8'h00);
        chk("overview", 32'h0, {31'h0, overview});
        period <= 8'h00;
        repeat (60) @(posedge clk);
        stat(8'h03, 8'h02);
        chk("overview", 32'h1, {31'h0, overview});
        bus_wr(TA, 8'h3E);
        repeat (3) @(posedge clk);
        chk("overview", 32'h0, {31'h0, overview});
        bus_rd(TA);
        chk("control", 32'h0000003E, rd);
        $display("test heartbeat done");
        period <= 8'h02;
        repeat (20) @(posedge clk);
        stat(8'h01, 8'h01);
        period <= 8'h14;
        peer_high <= 1'b1;
        bus_wr(LA, 8'h04);
        repeat (60) @(posedge clk);
        stat(8'h02, 8'h02);
        bus_wr(TA, 8'h3F);
        // Counter runs on across a direction change; let a heartbeat pass
        repeat (40) @(posedge clk);
        bus_wr(LA, 8'h04);
        repeat (100) @(posedge clk);
        stat(8'h03, 8'h00);
        bus_wr(LA, 8'h0C);
        wait (high_link.heartbeat === 1'b1);
        u_peer.send_tone();
        repeat (3) @(posedge clk);
        stat(8'h07, 8'h05);
        // Tone on the port that is not supervised
        peer_high <= 1'b0;
        period <= 8'h00;
        bus_wr(LA, 8'h0C);
        u_peer.send_tone();
        repeat (3) @(posedge clk);
        stat(8'h04, 8'h00);
        $display("test direction done");
        conclude();
    end
endmodule
`default_nettype wire
